// ---- dv/swd_packet_target_port_bench.sv ----
// Bench: host and target joined on l1; a second target on l2 is
// bit-banged by the bench to break the host side's rules.
// Assumes 125 MHz system clock and HALF of 5.
`timescale 1ns/1ps
module swd_packet_target_port_bench;
	localparam int HALF = 5;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic ce = 1'h1;
	logic hsel = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic busy = 1'h0;
	logic [31:0] rdata = 32'h0;
	logic hready, hresp, hdr_vld, ap, rnw, wr_vld, fault, fault2, sc_q;
	logic [1:0] addr;
	logic [31:0] hrdata, wdata, stat, junk;
	int err_count = 0;
	int num_checks = 0;
	int hdr_n = 0;
	int wr_n = 0;
	int rise_n = 0;
	int rise_hdr = 0;
	int rise_wr = 0;
	swp_if l1();
	swp_if l2();
	always #4 clk = ~clk;
	swp_host #(.HALF(HALF)) swp_host_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CE(ce), .I_HSEL(hsel), .I_HADDR(haddr),
		.I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
		.O_HREADYOUT(hready), .O_HRESP(hresp), .O_HRDATA(hrdata), .LINK(l1.host));
	swp_target swp_target_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CE(ce), .LINK(l1.target), .I_BUSY(busy),
		.I_RDATA(rdata), .O_HDR_VLD(hdr_vld), .O_AP(ap), .O_RNW(rnw), .O_ADDR(addr), .O_WR_VLD(wr_vld),
		.O_WDATA(wdata), .O_FAULT(fault));
	swp_target swp_target_x_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CE(ce), .LINK(l2.target), .I_BUSY(busy),
		.I_RDATA(rdata), .O_HDR_VLD(), .O_AP(), .O_RNW(), .O_ADDR(), .O_WR_VLD(), .O_WDATA(), .O_FAULT(fault2));
	swp_checker swp_checker_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .swclk(l1.swclk), .t_out(l1.t_out),
		.t_oe_n(l1.t_oe_n), .h_out(l1.h_out), .h_oe_n(l1.h_oe_n), .swdio(l1.swdio));
	always @(posedge clk)
	begin
		sc_q <= l1.swclk;
		if (l1.swclk && !sc_q)
			rise_n <= rise_n + 1;
		// Rise count at each strobe; the difference is free of divider phase
		if (hdr_vld === 1'h1)
		begin
			hdr_n <= hdr_n + 1;
			rise_hdr <= rise_n;
		end
		if (wr_vld === 1'h1)
		begin
			wr_n <= wr_n + 1;
			rise_wr <= rise_n;
		end
	end
	////////////////////////////////////////
	task final_report;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	task hang;
		err_count++;
		$display("ERROR %0t: timeout", $time);
		final_report;
	endtask : hang
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task rdy;
		int n;
		@(posedge clk);
		for (n = 0; hready !== 1'h1 && n < 50; n++)
			@(posedge clk);
		if (n == 50)
			hang;
	endtask : rdy
	task ahb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'h1;
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		rdy;
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		r = hrdata;
	endtask : ahb
	// Poll busy; retried packets can take thousands of cycles
	task go(input logic [31:0] c);
		int n;
		ahb(1'h1, swp_pkg::OFS_CTRL, c, junk);
		stat = 32'h1;
		for (n = 0; stat[0] !== 1'h0 && n < 3000; n++)
			ahb(1'h0, swp_pkg::OFS_STAT, 32'h0, stat);
		if (n == 3000)
			hang;
	endtask : go
	////////////////////////////////////////
	// Bench-driven host on l2, bit changes on the falling edge
	task bb_bit(input logic b, input logic oe_n, output logic s);
		l2.swclk <= 1'h0;
		l2.h_out <= b;
		l2.h_oe_n <= oe_n;
		repeat (HALF) @(posedge clk);
		s = l2.swdio;
		l2.swclk <= 1'h1;
		repeat (HALF) @(posedge clk);
	endtask : bb_bit
	function automatic logic [7:0] hdr(input logic p, input logic r, input logic [1:0] ad, input logic bad);
		return {2'h2, ^{p, r, ad} ^ bad, ad, r, p, 1'h1};
	endfunction : hdr
	task bb_pkt(input logic [7:0] h, input logic [32:0] w, output logic [2:0] a);
		logic s;
		for (int k = 0; k < 49; k++)
		begin
			bb_bit(k < 8 ? h[k] : (k > 12 && k < 46 ? w[k-13] : 1'h0), k > 7 && k < 13, s);
			if (k > 8 && k < 12)
				a[k-9] = s;
		end
	endtask : bb_pkt
	task bb_lrst;
		logic s;
		for (int k = 0; k < 67; k++)
			bb_bit(k < 64, 1'h0, s);
	endtask : bb_lrst
	////////////////////////////////////////
	task t_write;
		go(32'h100);
		ahb(1'h1, swp_pkg::OFS_WDATA, 32'h8e51_c0a3, junk);
		go(32'h13);
		chk(rise_wr - rise_hdr, swp_pkg::B_WPAR - swp_pkg::B_HDR_LAST);
		chk(hresp, 1'h0);
		chk(wr_n, 32'h1);
		chk(wdata, 32'h8e51_c0a3);
		chk({ap, rnw, addr}, 4'ha);
		chk(stat[3:1], swp_pkg::ACK_OK);
		chk(fault, 1'h0);
		chk(l1.t_oe_n, 1'h1);
		$display("write test done");
	endtask : t_write
	task t_read;
		for (int i = 0; i < 4; i++)
		begin
			rdata <= 32'h8000_0001 ^ {8{i[3:0]}};
			go({27'h0, i[1:0], 1'h1, i[0], 1'h1});
			ahb(1'h0, swp_pkg::OFS_RDATA, 32'h0, junk);
			chk(junk, 32'h8000_0001 ^ {8{i[3:0]}});
			chk({ap, rnw, addr}, {i[0], 1'h1, i[1:0]});
			chk(stat[4:1], {1'h0, swp_pkg::ACK_OK});
		end
		$display("read test done");
	endtask : t_read
	task t_wait;
		int h0;
		h0 = hdr_n;
		busy <= 1'h1;
		go(32'h7);
		chk(stat[8:1], {swp_pkg::WAIT_MAX, 2'h2, swp_pkg::ACK_WAIT});
		chk(hdr_n, h0);
		busy <= 1'h0;
		go(32'h7);
		chk(stat[3:1], swp_pkg::ACK_OK);
		$display("wait test done");
	endtask : t_wait
	task t_fault;
		logic [2:0] a;
		logic [31:0] d;
		d = 32'hc3a5_5a3c;
		bb_lrst;
		bb_pkt(hdr(1'h0, 1'h0, 2'h1, 1'h1), 33'h0, a);
		chk(a, 3'h7);
		bb_lrst;
		bb_pkt(hdr(1'h1, 1'h0, 2'h3, 1'h0), {~^d, d}, a);
		chk(a, swp_pkg::ACK_OK);
		chk(fault2, 1'h1);
		bb_pkt(hdr(1'h1, 1'h0, 2'h3, 1'h0), {^d, d}, a);
		chk(a, swp_pkg::ACK_FAULT);
		bb_lrst;
		chk(fault2, 1'h0);
		bb_pkt(hdr(1'h0, 1'h0, 2'h0, 1'h0), {^d, d}, a);
		chk(a, swp_pkg::ACK_OK);
		$display("fault test done");
	endtask : t_fault
	initial
	begin
		l2.swclk = 1'h0;
		l2.h_out = 1'h0;
		l2.h_oe_n = 1'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		t_write;
		t_read;
		t_wait;
		t_fault;
		final_report;
	end
endmodule : swd_packet_target_port_bench

// ---- dv/swp_checker.sv ----
// Link checker for the host/target pair on one interface.
// Assumes HALF of 5 system clocks per link half period.
`timescale 1ns/1ps
module swp_checker (
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	input wire logic swclk,
	input wire logic t_out,
	input wire logic t_oe_n,
	input wire logic h_out,
	input wire logic h_oe_n,
	input wire logic swdio
);
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_RST_N);
	logic clk_q;
	logic [5:0] rise_q;
	logic [1:0] ack_n_q;
	logic [2:0] ack_q;
	////////////////////////////////////////
	// Rises and ack bits while target drives
	always_ff @(posedge I_CLK_SYS)
	begin
		clk_q <= swclk;
		if (!I_RST_N || t_oe_n)
		begin
			rise_q <= 6'h00;
			ack_n_q <= 2'h0;
		end
		else
		begin
			if (swclk && !clk_q)
				rise_q <= rise_q + 6'h01;
			if (!swclk && clk_q && ack_n_q != 2'h3)
			begin
				ack_n_q <= ack_n_q + 2'h1;
				ack_q <= {swdio, ack_q[2:1]};
			end
		end
	end
	sequence clk_high;
		swclk [*5];
	endsequence
	sequence drive_start;
		$fell(t_oe_n);
	endsequence
	////////////////////////////////////////
	a_link_high:
		assert property ($rose(swclk) |-> clk_high ##1 !swclk) else $error("link high phase wrong");
	a_no_contention:
		assert property (!(!t_oe_n && !h_oe_n)) else $error("both ends drive");
	a_rel_reset:
		assert property ($rose(I_RST_N) |-> t_oe_n) else $error("line held in reset");
	a_target_rise:
		assert property (!t_oe_n && $past(t_oe_n) == 1'h0 && $changed(t_out) |-> swclk) else $error("target bit off rise");
	a_ack_on_rise:
		assert property (drive_start |-> swclk) else $error("ack not on rise");
	a_host_quiet:
		assert property (drive_start |-> $past(h_oe_n, 5)) else $error("no turnaround");
	a_host_fall:
		assert property (!h_oe_n && $changed(h_out) |-> !swclk) else $error("host bit off fall");
	a_drive_window:
		assert property (rise_q <= 6'h24) else $error("target drives too long");
	a_ack_code:
		assert property (ack_n_q == 2'h3 |-> $onehot(ack_q)) else $error("bad ack code");
endmodule : swp_checker

// ---- rtl/swp_host.sv ----
// Host end of the serial wire debug link, ordered over AHB-Lite.
// Assumes a single AHB-Lite master; link clock is made here by a divider.
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module swp_host #(
	parameter int HALF = swp_pkg::SWCLK_HALF_CYC
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	input wire logic I_CE,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	output logic [31:0] O_HRDATA,
	swp_if.host LINK
);

	//////////////////////////////////////////////////////////////////////////
	// State
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_PKT = 4'b0010,
		H_GAP = 4'b0100,
		H_LRST = 4'b1000
	} swp_hst_st_e;

	typedef struct packed {
		swp_hst_st_e st;
		logic [7:0] cnt;
		logic swclk;
		logic dout;
		logic oe_n;
		logic [1:0] dio_sy;
		logic [5:0] k;
		logic [5:0] gap;
		logic [2:0] wcnt;
		logic retry;
		logic ap;
		logic rnw;
		logic [1:0] addr;
		logic [31:0] wd;
		logic [32:0] wsh;
		logic [32:0] rsh;
		logic [2:0] ack;
		logic perr;
		logic abort;
		logic wp;
		logic [11:0] wa;
		logic rdy;
		logic [31:0] hrdata;
	} swp_hst_s;

	swp_hst_s q;
	swp_hst_s d;
	logic fall;
	logic samp;
	logic din;
	logic [7:0] hdr;
	logic [2:0] nack;
	logic [32:0] nrsh;

	assign fall = q.cnt == 8'(HALF - 1);
	assign samp = q.cnt == 8'(2 * HALF - 1);
	assign din = q.dio_sy[1];
	assign hdr = {2'b10, ^{q.addr, q.rnw, q.ap}, q.addr, q.rnw, q.ap, 1'b1};
	assign nack = {din, q.ack[2:1]};
	assign nrsh = {din, q.rsh[32:1]};

	//////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		d = q;
		if (I_CE)
		begin
			d.dio_sy = {q.dio_sy[0], LINK.swdio};
			// Free-running divider; host edges and samples are placed by it
			d.cnt = samp ? 8'h00 : q.cnt + 8'h01;
			d.swclk = samp ? 1'b1 : (fall ? 1'b0 : q.swclk);
			if (fall)
			begin
				d.dout = 1'b0;
				d.oe_n = 1'b0;
				unique case (q.st)
					H_IDLE:
					begin
					end
					H_PKT:
					begin
						d.k = q.k + 6'h01;
						if (q.k <= swp_pkg::B_HDR_LAST)
						begin
							d.dout = hdr[q.k[2:0]];
						end
						else if (q.k == swp_pkg::B_END)
						begin
							d.st = H_GAP;
							d.gap = 6'h00;
						end
						else if (!q.rnw && q.k >= swp_pkg::B_WD0)
						begin
							d.dout = q.wsh[0];
							d.wsh = {1'b0, q.wsh[32:1]};
						end
						else if (!(q.rnw && q.k == swp_pkg::B_WPAR))
						begin
							d.oe_n = 1'b1;
						end
					end
					H_GAP:
					begin
						d.gap = q.gap + 6'h01;
						if (q.gap == swp_pkg::IDLE_CLKS - 6'h01)
						begin
							d.st = q.retry ? H_PKT : H_IDLE;
							d.retry = 1'b0;
							d.k = 6'h00;
							d.wsh = {^q.wd, q.wd};
						end
					end
					H_LRST:
					begin
						d.dout = 1'b1;
						d.gap = q.gap + 6'h01;
						if (q.gap == swp_pkg::LRST_SEND - 6'h01)
						begin
							d.st = H_GAP;
							d.gap = 6'h00;
						end
					end
				endcase
			end
			if (samp && q.st == H_PKT && q.k > swp_pkg::B_ACK0_HOST)
			begin
				if (q.k <= swp_pkg::B_ACK_LAST)
				begin
					d.ack = nack;
				end
				if (q.k == swp_pkg::B_ACK_LAST)
				begin
					unique case (nack)
						swp_pkg::ACK_OK:
						begin
							d.wcnt = 3'h0;
						end
						swp_pkg::ACK_WAIT:
						begin
							d.wcnt = q.wcnt + 3'h1;
							d.abort = q.wcnt + 3'h1 == swp_pkg::WAIT_MAX;
							d.retry = q.wcnt + 3'h1 != swp_pkg::WAIT_MAX;
						end
						swp_pkg::ACK_FAULT:
						begin
							d.abort = 1'b1;
						end
						default:
						begin
							// No ack: stop at once so no data bit looks like a start bit
							d.abort = 1'b1;
							d.st = H_GAP;
							d.gap = 6'h00;
						end
					endcase
				end
				if (q.rnw && q.k > swp_pkg::B_ACK_LAST && q.k <= swp_pkg::B_RDAT_LAST)
				begin
					d.rsh = nrsh;
					if (q.k == swp_pkg::B_RDAT_LAST && q.ack == swp_pkg::ACK_OK && ^nrsh)
					begin
						d.perr = 1'b1;
						d.abort = 1'b1;
					end
				end
			end
			// AHB-Lite slave, zero wait states, always OKAY
			d.rdy = 1'b1;
			if (q.wp)
			begin
				d.wp = 1'b0;
				if (q.wa == swp_pkg::OFS_WDATA)
				begin
					d.wd = I_HWDATA;
				end
				if (q.wa == swp_pkg::OFS_CTRL)
				begin
					d.ap = I_HWDATA[swp_pkg::CTRL_AP];
					d.rnw = I_HWDATA[swp_pkg::CTRL_RNW];
					d.addr = I_HWDATA[swp_pkg::CTRL_ADDR +: 2];
					if (q.st == H_IDLE && I_HWDATA[swp_pkg::CTRL_GO])
					begin
						d.st = H_PKT;
						d.k = 6'h00;
						d.wsh = {^q.wd, q.wd};
						d.wcnt = 3'h0;
						d.abort = 1'b0;
						d.perr = 1'b0;
					end
					else if (q.st == H_IDLE && I_HWDATA[swp_pkg::CTRL_LRST])
					begin
						d.st = H_LRST;
						d.gap = 6'h00;
					end
				end
			end
			if (I_HSEL && I_HTRANS[1] && I_HREADY)
			begin
				d.wp = I_HWRITE;
				d.wa = I_HADDR[11:0];
				d.hrdata = 32'h0;
				// Only whole-word transfers are mapped; narrower ones read zero
				if (!I_HWRITE && I_HADDR[31:12] == 20'h00000 && I_HSIZE == 3'h2)
				begin
					unique case (I_HADDR[11:0])
						swp_pkg::OFS_CTRL: d.hrdata = {27'h0, q.addr, q.rnw, q.ap, 1'b0};
						swp_pkg::OFS_WDATA: d.hrdata = q.wd;
						swp_pkg::OFS_RDATA: d.hrdata = q.rsh[31:0];
						swp_pkg::OFS_STAT: d.hrdata = {23'h0, q.wcnt, q.abort, q.perr, q.ack, q.st != H_IDLE};
						default: d.hrdata = 32'h0;
					endcase
				end
				if (I_HADDR[31:12] != 20'h00000 || I_HSIZE != 3'h2)
				begin
					d.wa = 12'hfff;
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RST_N)
		begin
			q <= '0;
			q.st <= H_IDLE;
			q.rdy <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	assign LINK.swclk = q.swclk;
	assign LINK.h_out = q.dout;
	assign LINK.h_oe_n = q.oe_n;
	assign O_HREADYOUT = q.rdy;
	assign O_HRESP = 1'b0;
	assign O_HRDATA = q.hrdata;

endmodule : swp_host

// ---- rtl/swp_if.sv ----
// Two-wire debug link between the host end and the target end.
// Assumes an external pull-up: an undriven line reads high.
`timescale 1ns/1ps
interface swp_if;
	logic swclk;
	logic t_out;
	logic t_oe_n;
	logic h_out;
	logic h_oe_n;
	logic swdio;

	// Pull-up resolution; target wins if both ever drive
	assign swdio = !t_oe_n ? t_out : (!h_oe_n ? h_out : 1'b1);

	modport target(input swclk, input swdio, output t_out, output t_oe_n);
	modport host(output swclk, output h_out, output h_oe_n, input swdio);
endinterface : swp_if

// ---- rtl/swp_pkg.sv ----
// Shared constants for the serial wire debug packet target and host ends.
// Assumes both ends count link rising edges from the start bit as index 0.
package swp_pkg;

	//////////////////////////////////////////////////////////////////////////
	// Packet layout, counted in link rising edges from the start bit
	localparam int PKT_CLKS = 46;
	localparam logic [5:0] B_AP = 6'h01;
	localparam logic [5:0] B_HPAR = 6'h05;
	localparam logic [5:0] B_PARK = 6'h07;
	localparam logic [5:0] B_DATA = 6'h0b;
	localparam logic [5:0] B_REL = 6'h2c;
	localparam logic [5:0] B_WD0 = 6'h0d;
	localparam logic [5:0] B_WPAR = 6'h2d;
	localparam logic [5:0] B_END = 6'h2e;
	localparam logic [5:0] B_HDR_LAST = 6'h07;
	localparam logic [5:0] B_RDAT_LAST = 6'h2d;
	localparam logic [5:0] B_ACK_LAST = 6'h0c;
	// Host samples trail the target's rises by one, so ack is taken after this index
	localparam logic [5:0] B_ACK0_HOST = 6'h09;

	//////////////////////////////////////////////////////////////////////////
	// Acknowledge codes, line reset and idle counts
	localparam logic [2:0] ACK_OK = 3'h1;
	localparam logic [2:0] ACK_WAIT = 3'h2;
	localparam logic [2:0] ACK_FAULT = 3'h4;
	localparam logic [5:0] LRST_ONES = 6'h32;
	localparam logic [5:0] LRST_SEND = 6'h34;
	localparam logic [5:0] IDLE_CLKS = 6'h03;
	localparam logic [2:0] WAIT_MAX = 3'h4;

	//////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int SYS_PERIOD_NS = 8;
	localparam int SWCLK_PERIOD_NS = 80;
	localparam int SWCLK_HALF_CYC = SWCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);

	//////////////////////////////////////////////////////////////////////////
	// Host register map and fields
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_WDATA = 12'h004;
	localparam logic [11:0] OFS_RDATA = 12'h008;
	localparam logic [11:0] OFS_STAT = 12'h00c;
	localparam int CTRL_GO = 0;
	localparam int CTRL_AP = 1;
	localparam int CTRL_RNW = 2;
	localparam int CTRL_ADDR = 3;
	localparam int CTRL_LRST = 8;
	localparam int STAT_BUSY = 0;
	localparam int STAT_ACK = 1;
	localparam int STAT_PERR = 4;
	localparam int STAT_ABORT = 5;
	localparam int STAT_WCNT = 6;

endpackage : swp_pkg

// ---- rtl/swp_target.sv ----
// Target end of the serial wire debug packet link.
// Assumes the link clock is several times slower than I_CLK_SYS (both pins are synchronised).
//
// Notes on behaviour
// - Packet is 46 clocks: request, ack, data.
// - Host shifts on falling, target samples rising.
// - Target drives ack and read data on rising.
// - Data phase only live after OK ack.
// - Host starts every header with a one.
// - Port-select one means access port.
// - Direction one means read from target.
// - Two address bits select the register.
// - Header parity is even over four bits.
// - Bad header parity gets no ack.
// - Host sends stop zero, park one.
// - Ack 001/010/100 reports previous transfer.
// - Read with WAIT leaves line undriven.
// - Write with WAIT ignores data phase.
// - Host gives up after four WAITs.
// - Host aborts on FAULT.
// - Bad write parity gives FAULT next packet.
// - Host aborts on read parity error.
// - First turnaround half cycle, ack on rising.
// - Write turnaround one and a half cycles.
// - All fields shift least significant first.
// - Low clocks between packets are idle.
`timescale 1ns/1ps
module swp_target (
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	input wire logic I_CE,
	swp_if.target LINK,
	input wire logic I_BUSY,
	input wire logic [31:0] I_RDATA,
	output logic O_HDR_VLD,
	output logic O_AP,
	output logic O_RNW,
	output logic [1:0] O_ADDR,
	output logic O_WR_VLD,
	output logic [31:0] O_WDATA,
	output logic O_FAULT
);

	//////////////////////////////////////////////////////////////////////////
	// State
	typedef enum logic [5:0] {
		T_IDLE = 6'b000001,
		T_HDR = 6'b000010,
		T_ACK = 6'b000100,
		T_RD = 6'b001000,
		T_WR = 6'b010000,
		T_LRST = 6'b100000
	} swp_tgt_st_e;

	typedef struct packed {
		swp_tgt_st_e st;
		logic [5:0] bitc;
		logic [2:0] clk_sy;
		logic [1:0] dio_sy;
		logic [3:0] hdr;
		logic hbad;
		logic [2:0] ack;
		logic drv;
		logic [32:0] sh;
		logic fault;
		logic [5:0] ones;
		logic dout;
		logic oe_n;
		logic hdr_vld;
		logic wr_vld;
		logic [31:0] wdata;
	} swp_tgt_s;

	swp_tgt_s q;
	swp_tgt_s d;
	logic rise;
	logic din;
	logic [32:0] nsh;

	assign rise = q.clk_sy[1] & ~q.clk_sy[2];
	assign din = q.dio_sy[1];
	assign nsh = {din, q.sh[32:1]};

	//////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		d = q;
		if (I_CE)
		begin
			d.hdr_vld = 1'b0;
			d.wr_vld = 1'b0;
			// Only stage two onward is read by logic
			d.clk_sy = {q.clk_sy[1:0], LINK.swclk};
			d.dio_sy = {q.dio_sy[0], LINK.swdio};
			if (rise)
			begin
				d.bitc = q.bitc + 6'h01;
				unique case (q.st)
					T_IDLE:
					begin
						// Low clocks are idle; a high bit is a start bit
						if (din)
						begin
							d.st = T_HDR;
							d.bitc = swp_pkg::B_AP;
						end
					end
					T_HDR:
					begin
						if (q.bitc < swp_pkg::B_HPAR)
						begin
							// Shift in port select, direction, address low first
							d.hdr = {din, q.hdr[3:1]};
						end
						if (q.bitc == swp_pkg::B_HPAR)
						begin
							d.hbad = ^{q.hdr, din};
						end
						// Stop and park bits are not checked; a bad pair is acked the same as a good header
						if (q.bitc == swp_pkg::B_PARK)
						begin
							if (q.hbad)
							begin
								d.st = T_IDLE;
							end
							else
							begin
								d.st = T_ACK;
								// Status of the previous transfer, fault first
								if (q.fault)
								begin
									d.ack = swp_pkg::ACK_FAULT;
								end
								else if (I_BUSY)
								begin
									d.ack = swp_pkg::ACK_WAIT;
								end
								else
								begin
									d.ack = swp_pkg::ACK_OK;
								end
								d.drv = ~q.fault & ~I_BUSY;
								d.hdr_vld = ~q.fault & ~I_BUSY;
							end
						end
					end
					T_ACK:
					begin
						if (q.bitc == swp_pkg::B_DATA)
						begin
							if (q.hdr[1] && q.drv)
							begin
								d.dout = I_RDATA[0];
								d.sh = {1'b0, ^I_RDATA, I_RDATA[31:1]};
								d.st = T_RD;
							end
							else
							begin
								// Write turnaround, or a read that was not OK
								d.oe_n = 1'b1;
								d.st = q.hdr[1] ? T_RD : T_WR;
							end
						end
						else
						begin
							// Drive starts on the rising edge inside the first turnaround
							d.dout = q.ack[0];
							d.ack = {1'b0, q.ack[2:1]};
							d.oe_n = 1'b0;
						end
					end
					T_RD:
					begin
						if (q.bitc == swp_pkg::B_REL)
						begin
							d.oe_n = 1'b1;
							d.st = T_IDLE;
						end
						else if (q.drv)
						begin
							d.dout = q.sh[0];
							d.sh = {1'b0, q.sh[32:1]};
						end
					end
					T_WR:
					begin
						if (q.bitc >= swp_pkg::B_WD0)
						begin
							d.sh = nsh;
						end
						if (q.bitc == swp_pkg::B_WPAR)
						begin
							d.st = T_IDLE;
							// Data of a non-OK packet is clocked through and dropped
							if (q.drv)
							begin
								if (^nsh)
								begin
									d.fault = 1'b1;
								end
								else
								begin
									d.wr_vld = 1'b1;
									d.wdata = nsh[31:0];
								end
							end
						end
					end
					T_LRST:
					begin
						if (!din)
						begin
							d.st = T_IDLE;
						end
					end
				endcase
				// Own drive is not counted; pull-up during turnaround tops out at 33 ones
				if (din && q.oe_n)
				begin
					d.ones = (q.ones == swp_pkg::LRST_ONES) ? q.ones : q.ones + 6'h01;
				end
				else
				begin
					d.ones = 6'h00;
				end
				if (din && q.oe_n && q.ones == swp_pkg::LRST_ONES - 6'h01)
				begin
					d.st = T_LRST;
					d.fault = 1'b0;
					d.oe_n = 1'b1;
					d.hdr_vld = 1'b0;
					d.wr_vld = 1'b0;
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RST_N)
		begin
			q <= '0;
			q.st <= T_IDLE;
			q.oe_n <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	assign LINK.t_out = q.dout;
	assign LINK.t_oe_n = q.oe_n;
	assign O_HDR_VLD = q.hdr_vld;
	assign O_AP = q.hdr[0];
	assign O_RNW = q.hdr[1];
	assign O_ADDR = q.hdr[3:2];
	assign O_WR_VLD = q.wr_vld;
	assign O_WDATA = q.wdata;
	assign O_FAULT = q.fault;

endmodule : swp_target
